// ===== hw/ocpwm_channel.sv
// Functional notes
// - Modes 110 and 111 run the modulator
// - Low fault input shuts mode 111 down
// - A is active duty, B buffers next duty
// - Buffer copied to active duty at period
// - Period flag raised each modulator period
// - High at period boundary, low at duty
// - Fault A serves 1-4, B serves 5-8
// - Faulted modulator output goes high impedance
// - Shutdown path is independent of clock
// - Shutdown holds until fault gone and rewrite
// - Fault sets the channel event flag
// - Fault status bit 4, read only, sticky
// - Fault keeps control in sleep or idle
// - Period is period value plus one counts
// - A=0 from start: first pass no pulse
// - A=0, B=period: one-clock low then high
// - A>=B: rise at A, fall after wrap
// - B beyond period: rise only, no flag
// - All zero: continuous delayed pulses
// - A beyond period: output stays low
// - Writing 101 drives pin low at once
// - Pin rises one clock after A match
// - Event flag two clocks after falling edge
//
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
`default_nettype none
module ocpwm_channel
   import ocpwm_pkg::*;
#(
   parameter int CHANNEL = 1,
   parameter int WIDTH   = 16
)
(
   // Clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   // Wishbone slave
   input  wire logic                         wb_cyc_i,
   input  wire logic                         wb_stb_i,
   input  wire logic                         wb_we_i,
   input  wire logic [ocpwm_pkg::ADDR_W-1:0] wb_adr_i,
   input  wire logic [3:0]                   wb_sel_i,
   input  wire logic [31:0]                  wb_dat_i,
   output logic      [31:0]                  wb_dat_o,
   output logic                              wb_ack_o,
   // Timebase
   input  wire logic [WIDTH-1:0]             timebase_count_i,
   input  wire logic                         timebase_advance_i,
   input  wire logic                         period_match_i,
   // Fault inputs, active low
   input  wire logic                         fault_input_a_i,
   input  wire logic                         fault_input_b_i,
   // Output pin
   output logic                              compare_output_pin_o,
   output logic                              compare_output_pin_oe_o,
   // Event flags
   output logic                              channel_event_flag_o,
   output logic                              period_event_flag_o
);
   import ocpwm_pkg::*;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   ocpwm_mode_e                mode;
   ocpwm_state_e               state;
   ocpwm_state_e               next_state;
   logic [WIDTH-1:0]           compare_value_a;
   logic [WIDTH-1:0]           compare_value_b;
   logic                       channel_event_flag;
   logic                       period_event_flag;
   logic [EVT_DELAY_CYC-1:0]   fall_pipe;
   logic                       pin_q;
   logic                       oe_q;
   logic                       ack_q;
   logic [31:0]                dat_q;

   logic                       bus_req;
   logic                       wr_en;
   logic                       wr_lo;
   logic                       wr_hi;
   logic                       wr_ctrl;
   logic                       wr_cmpa;
   logic                       wr_cmpb;
   logic                       wr_stat;
   logic [WIDTH-1:0]           wr_data16;
   logic [31:0]                rd_data;
   logic                       is_pwm;
   logic                       is_dual;
   logic                       is_fault_mode;
   logic                       mode_rewrite;
   logic                       fault_n_sel;
   logic                       fault_now;
   logic                       hit_a;
   logic                       hit_b;
   logic                       fall_evt;
   logic                       boundary;
   logic                       duty_zero;
   logic [WIDTH-1:0]           cmp_vals [2];
   logic [1:0]                 hits;
   logic                       set_ch;
   logic                       set_per;
   logic                       clr_ch;
   logic                       clr_per;

   ocpwm_fault_if flt ();

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   assign bus_req   = wb_cyc_i & wb_stb_i;
   assign wr_en     = bus_req & wb_we_i & ack_q;
   assign wr_lo     = wr_en & wb_sel_i[0];
   assign wr_hi     = wr_en & wb_sel_i[1];
   assign wr_ctrl   = wr_lo & (wb_adr_i == ADDR_CTRL);
   assign wr_cmpa   = (wr_lo | wr_hi) & (wb_adr_i == ADDR_CMPA) & ~is_pwm;
   assign wr_cmpb   = (wr_lo | wr_hi) & (wb_adr_i == ADDR_CMPB);
   assign wr_stat   = wr_lo & (wb_adr_i == ADDR_STAT);
   assign wr_data16 = wb_dat_i[WIDTH-1:0];

   always_comb
   begin
      rd_data = 32'h0000_0000;
      unique case (wb_adr_i)
         ADDR_CTRL:
         begin
            rd_data[CTRL_MODE_MSB:CTRL_MODE_LSB] = mode;
            rd_data[CTRL_FLT_BIT]                = flt.status;
         end
         ADDR_CMPA:
         begin
            rd_data[WIDTH-1:0] = compare_value_a;
         end
         ADDR_CMPB:
         begin
            rd_data[WIDTH-1:0] = compare_value_b;
         end
         ADDR_STAT:
         begin
            rd_data[STAT_CH_BIT]  = channel_event_flag;
            rd_data[STAT_PER_BIT] = period_event_flag;
         end
         default:
         begin
            rd_data = 32'h0000_0000;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Wishbone answer
   // ------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end
      else
      begin
         ack_q <= bus_req & ~ack_q;
         if (bus_req & ~ack_q)
         begin
            dat_q <= rd_data;
         end
      end
   end

   // ------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------
   assign is_pwm        = (mode == MODE_PWM) | (mode == MODE_PWM_FLT);
   assign is_dual       = (mode == MODE_DUAL);
   assign is_fault_mode = (mode == MODE_PWM_FLT);
   assign mode_rewrite  = wr_ctrl &
                          (wb_dat_i[CTRL_MODE_MSB:CTRL_MODE_LSB] == MODE_PWM |
                           wb_dat_i[CTRL_MODE_MSB:CTRL_MODE_LSB] == MODE_PWM_FLT);

   // ------------------------------------------------------------
   // Fault selection and shutdown
   // ------------------------------------------------------------
   assign fault_n_sel = (CHANNEL <= 4) ? fault_input_a_i : fault_input_b_i;
   assign fault_now   = is_fault_mode & ~fault_n_sel;

   assign flt.fault_n      = fault_n_sel;
   assign flt.fault_mode   = is_fault_mode;
   assign flt.mode_rewrite = mode_rewrite;

   ocpwm_fault u_fault
   (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .flt   (flt)
   );

   // ------------------------------------------------------------
   // Compare units: A (active duty) and B (buffer)
   // ------------------------------------------------------------
   assign cmp_vals[0] = compare_value_a;
   assign cmp_vals[1] = compare_value_b;

   for (genvar g = 0; g < 2; g++)
   begin : g_cmp
      ocpwm_match
      #(
         .WIDTH (WIDTH)
      )
      u_match
      (
         .count_i   (timebase_count_i),
         .advance_i (timebase_advance_i),
         .value_i   (cmp_vals[g]),
         .hit_o     (hits[g])
      );
   end

   assign hit_a     = hits[0];
   assign hit_b     = hits[1];
   // Period boundary: the advance on which the count wraps to zero
   assign boundary  = period_match_i & is_pwm;
   assign duty_zero = (compare_value_b == ZERO16);
   // Second compare only counts while the pulse is up
   assign fall_evt  = is_dual & (state == ST_HIGH) & hit_b;

   // ------------------------------------------------------------
   // Pin state machine
   // ------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_LOW:
         begin
            if (is_dual & hit_a)
            begin
               next_state = ST_HIGH;
            end
            else if (boundary & ~duty_zero)
            begin
               next_state = ST_HIGH;
            end
         end
         ST_HIGH:
         begin
            if (fall_evt)
            begin
               next_state = ST_LOW;
            end
            else if (boundary)
            begin
               next_state = duty_zero ? ST_LOW : ST_HIGH;
            end
            else if (is_pwm & hit_a)
            begin
               next_state = ST_LOW;
            end
         end
         ST_SHUT:
         begin
            if (~flt.status)
            begin
               next_state = ST_LOW;
            end
         end
         default:
         begin
            next_state = ST_LOW;
         end
      endcase
      if (flt.status | fault_now)
      begin
         next_state = ST_SHUT;
      end
      else if (wr_ctrl)
      begin
         next_state = ST_LOW;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state <= ST_LOW;
         pin_q <= 1'b0;
         oe_q  <= 1'b0;
      end
      else
      begin
         state <= next_state;
         pin_q <= (next_state == ST_HIGH);
         // A write of mode 000 must release the pin at once, not one cycle late
         oe_q  <= (next_state != ST_SHUT) &
                  (wr_ctrl ? (wb_dat_i[CTRL_MODE_MSB:CTRL_MODE_LSB] != MODE_OFF)
                           : (mode != MODE_OFF));
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mode            <= MODE_OFF;
         compare_value_a <= CMP_RST;
         compare_value_b <= CMP_RST;
      end
      else
      begin
         if (wr_ctrl)
         begin
            mode <= ocpwm_mode_e'(wb_dat_i[CTRL_MODE_MSB:CTRL_MODE_LSB]);
         end
         if (boundary)
         begin
            compare_value_a <= compare_value_b;
         end
         else if (wr_cmpa)
         begin
            compare_value_a <= wr_data16;
         end
         if (wr_cmpb)
         begin
            compare_value_b <= wr_data16;
         end
      end
   end

   // ------------------------------------------------------------
   // Event flags: set wins over write-one-to-clear
   // ------------------------------------------------------------
   assign set_ch  = fall_pipe[EVT_DELAY_CYC-1] | flt.evt;
   assign set_per = boundary;
   assign clr_ch  = wr_stat & wb_dat_i[STAT_CH_BIT];
   assign clr_per = wr_stat & wb_dat_i[STAT_PER_BIT];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         fall_pipe          <= '0;
         channel_event_flag <= 1'b0;
         period_event_flag  <= 1'b0;
      end
      else
      begin
         fall_pipe          <= {fall_pipe[EVT_DELAY_CYC-2:0], fall_evt};
         channel_event_flag <= set_ch | (channel_event_flag & ~clr_ch);
         period_event_flag  <= set_per | (period_event_flag & ~clr_per);
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign wb_ack_o             = ack_q;
   assign wb_dat_o             = dat_q;
   assign compare_output_pin_o = pin_q;
   // Clockless gate: a fault releases the pin at once, also in low power
   assign compare_output_pin_oe_o = oe_q & ~fault_now;
   assign channel_event_flag_o = channel_event_flag;
   assign period_event_flag_o  = period_event_flag;

endmodule
`default_nettype wire

// ===== hw/ocpwm_fault.sv
`default_nettype none
module ocpwm_fault
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Control side
   ocpwm_fault_if.unit flt
);
   logic set_now;
   logic clr_now;
   logic status;

   assign set_now = flt.fault_mode & ~flt.fault_n;
   // Recovery needs the pin high again and a fresh mode write
   assign clr_now = flt.mode_rewrite & flt.fault_n;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         status <= 1'b0;
      end
      else
      begin
         status <= set_now | (status & ~clr_now);
      end
   end

   assign flt.status = status;
   assign flt.evt    = set_now & ~status;
endmodule
`default_nettype wire

// ===== hw/ocpwm_match.sv
`default_nettype none
module ocpwm_match
#(
   parameter int WIDTH = 16
)
(
   // Timebase
   input  wire logic [WIDTH-1:0] count_i,
   input  wire logic             advance_i,
   // Compare value
   input  wire logic [WIDTH-1:0] value_i,
   // Result
   output logic                  hit_o
);
   // Only a freshly taken count value matches, so prescaled counts hit once
   assign hit_o = advance_i & (count_i == value_i);
endmodule
`default_nettype wire

// ===== inc/ocpwm_fault_if.sv
`default_nettype none
interface ocpwm_fault_if;
   logic fault_n;
   logic fault_mode;
   logic mode_rewrite;
   logic status;
   logic evt;

   modport unit
   (
      input  fault_n,
      input  fault_mode,
      input  mode_rewrite,
      output status,
      output evt
   );

   modport ctrl
   (
      output fault_n,
      output fault_mode,
      output mode_rewrite,
      input  status,
      input  evt
   );
endinterface
`default_nettype wire

// ===== inc/ocpwm_pkg.sv
`default_nettype none
package ocpwm_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam int          ADDR_W      = 4;
   localparam logic [3:0]  ADDR_CTRL   = 4'h0;
   localparam logic [3:0]  ADDR_CMPA   = 4'h4;
   localparam logic [3:0]  ADDR_CMPB   = 4'h8;
   localparam logic [3:0]  ADDR_STAT   = 4'hc;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int          CTRL_MODE_LSB = 0;
   localparam int          CTRL_MODE_MSB = 2;
   localparam int          CTRL_FLT_BIT  = 4;
   localparam int          STAT_CH_BIT   = 0;
   localparam int          STAT_PER_BIT  = 1;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [15:0] CMP_RST     = 16'h0000;
   localparam logic [15:0] ZERO16      = 16'h0000;

   // ------------------------------------------------------------
   // Timing: instruction clock equals clk_i (100 MHz)
   // ------------------------------------------------------------
   localparam int          CLK_MHZ         = 100;
   localparam int          TCY_MHZ         = 100;
   localparam int          EVT_DELAY_TCY   = 2;
   localparam int          EVT_DELAY_CYC   = (EVT_DELAY_TCY * CLK_MHZ + TCY_MHZ - 1) / TCY_MHZ;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_OFF     = 3'h0,
      MODE_LOW     = 3'h1,
      MODE_HIGH    = 3'h2,
      MODE_TOGGLE  = 3'h3,
      MODE_SINGLE  = 3'h4,
      MODE_DUAL    = 3'h5,
      MODE_PWM     = 3'h6,
      MODE_PWM_FLT = 3'h7
   } ocpwm_mode_e;

   typedef enum logic [1:0] {
      ST_LOW   = 2'h0,
      ST_HIGH  = 2'h1,
      ST_SHUT  = 2'h3
   } ocpwm_state_e;

endpackage
`default_nettype wire

// ===== tb/ocpwm_channel_sva.sv
`default_nettype none
module ocpwm_channel_sva
   import ocpwm_pkg::*;
#(
   parameter int CHANNEL = 1,
   parameter int WIDTH   = 16
)
(
   // Clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   // Wishbone
   input  wire logic                         wb_cyc_i,
   input  wire logic                         wb_stb_i,
   input  wire logic                         wb_we_i,
   input  wire logic [ocpwm_pkg::ADDR_W-1:0] wb_adr_i,
   input  wire logic [3:0]                   wb_sel_i,
   input  wire logic [31:0]                  wb_dat_i,
   input  wire logic [31:0]                  wb_dat_o,
   input  wire logic                         wb_ack_o,
   // Timebase
   input  wire logic [WIDTH-1:0]             timebase_count_i,
   input  wire logic                         timebase_advance_i,
   input  wire logic                         period_match_i,
   // Faults
   input  wire logic                         fault_input_a_i,
   input  wire logic                         fault_input_b_i,
   // Pin and flags
   input  wire logic                         compare_output_pin_o,
   input  wire logic                         compare_output_pin_oe_o,
   input  wire logic                         channel_event_flag_o,
   input  wire logic                         period_event_flag_o
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // -----------------------------------------
   // Shadow of software writes
   // -----------------------------------------
   logic [2:0]       mode_q;
   logic [WIDTH-1:0] cmpa_q;
   logic [WIDTH-1:0] cmpb_q;
   logic [2:0]       age;
   wire logic        wr_done  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   wire logic        wr_ctrl  = wr_done && (wb_adr_i == ADDR_CTRL) && wb_sel_i[0];
   wire logic        pwm_on   = (mode_q == MODE_PWM) || (mode_q == MODE_PWM_FLT);
   wire logic        wr_a     = wr_done && (wb_adr_i == ADDR_CMPA) && |wb_sel_i[1:0] && !pwm_on;
   wire logic        wr_b     = wr_done && (wb_adr_i == ADDR_CMPB) && |wb_sel_i[1:0];
   wire logic        flt_n    = (CHANNEL <= 4) ? fault_input_a_i : fault_input_b_i;
   wire logic        settled  = (age >= 3'h3);
   wire logic        dual_adv = (mode_q == MODE_DUAL) && settled && timebase_advance_i;
   wire logic [2:0]  next_age = wr_done ? 3'h0 : (age == 3'h7) ? age : age + 3'h1;

   always_ff @(posedge clk_i)
   begin
      age    <= rst_i ? 3'h0 : next_age;
      mode_q <= rst_i ? 3'h0 : wr_ctrl ? wb_dat_i[2:0] : mode_q;
      cmpa_q <= rst_i ? '0 : wr_a ? wb_dat_i[WIDTH-1:0] : cmpa_q;
      cmpb_q <= rst_i ? '0 : wr_b ? wb_dat_i[WIDTH-1:0] : cmpb_q;
   end

   // -----------------------------------------
   // Properties
   // -----------------------------------------
   sequence s_bfall;
      dual_adv && (timebase_count_i == cmpb_q) && compare_output_pin_o;
   endsequence
   sequence s_low_then_flag;
      !compare_output_pin_o ##2 channel_event_flag_o;
   endsequence
   property p_ack_next;
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack not a single pulse");
   property p_rst_out;
      $fell(rst_i) |-> !wb_ack_o && !compare_output_pin_oe_o && !channel_event_flag_o;
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("outputs active after reset");
   property p_flt_off;
      (mode_q == MODE_PWM_FLT && !flt_n) |-> !compare_output_pin_oe_o;
   endproperty
   a_flt_off: assert property (p_flt_off) else $error("pin driven during fault");
   property p_flt_flag;
      (mode_q == MODE_PWM_FLT && !flt_n) |=> channel_event_flag_o;
   endproperty
   a_flt_flag: assert property (p_flt_flag) else $error("fault left flag clear");
   property p_shut_hold;
      (mode_q == MODE_PWM_FLT && settled && !wr_done && !compare_output_pin_oe_o)
         |=> !compare_output_pin_oe_o;
   endproperty
   a_shut_hold: assert property (p_shut_hold) else $error("shutdown ended early");
   property p_per_flag;
      (pwm_on && period_match_i && timebase_advance_i && compare_output_pin_oe_o)
         |=> period_event_flag_o;
   endproperty
   a_per_flag: assert property (p_per_flag) else $error("period flag missing");
   property p_pwm_rise;
      (pwm_on && settled && period_match_i && timebase_advance_i && cmpb_q != '0
         && compare_output_pin_oe_o) |=> compare_output_pin_o;
   endproperty
   a_pwm_rise: assert property (p_pwm_rise) else $error("no rise at period");
   property p_dual_rise;
      (dual_adv && timebase_count_i == cmpa_q && !compare_output_pin_o) |=> compare_output_pin_o;
   endproperty
   a_dual_rise: assert property (p_dual_rise) else $error("no rise after first match");
   property p_dual_fall;
      s_bfall |=> s_low_then_flag;
   endproperty
   a_dual_fall: assert property (p_dual_fall) else $error("fall or flag late");
   property p_ctrl_low;
      (wr_ctrl && wb_dat_i[2:0] == MODE_DUAL) |=> !compare_output_pin_o;
   endproperty
   a_ctrl_low: assert property (p_ctrl_low) else $error("pin not low after mode write");
endmodule
`default_nettype wire

// ===== tb/ocpwm_channel_tb.sv
`default_nettype none
module ocpwm_channel_tb
   import ocpwm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic              clk_i   = 1'b0;
   logic              rst_i   = 1'b1;
   logic              wb_cyc  = 1'b0;
   logic              wb_stb  = 1'b0;
   logic              wb_we   = 1'b0;
   logic [ADDR_W-1:0] wb_adr  = '0;
   logic [3:0]        wb_sel  = 4'h0;
   logic [31:0]       wb_wdat = '0;
   logic [31:0]       wb_rdat;
   logic              wb_ack;
   logic [15:0]       tb_count;
   logic              tb_adv;
   logic              tb_match;
   logic              tmr_run = 1'b0;
   logic [15:0]       per_val = '0;
   logic              flt_a   = 1'b1;
   logic              flt_b   = 1'b1;
   logic              pin;
   logic              pin_oe;
   logic              ch_flag;
   logic              per_flag;
   logic [31:0]       rd;
   int                fails = 0;
   int                samples_checked = 0;
   int                n;
   // Period, first compare, second compare, rise cycle (0 none), channel flag
   int                dual_tab[5][5] = '{'{7, 5, 2, 7, 1}, '{7, 0, 4, 10, 1},
                                         '{7, 2, 9, 4, 0}, '{7, 9, 3, 0, 0}, '{0, 0, 0, 3, 1}};

   initial
   begin
      forever #5 clk_i = ~clk_i;
   end

   ocpwm_channel ocpwm_channel_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
      .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .timebase_count_i(tb_count),
      .timebase_advance_i(tb_adv), .period_match_i(tb_match), .fault_input_a_i(flt_a),
      .fault_input_b_i(flt_b), .compare_output_pin_o(pin), .compare_output_pin_oe_o(pin_oe),
      .channel_event_flag_o(ch_flag), .period_event_flag_o(per_flag));
   ocpwm_tmr_model ocpwm_tmr_model_i (.clk_i(clk_i), .rst_i(rst_i), .run_i(tmr_run),
      .period_value_i(per_val), .timebase_count_o(tb_count), .advance_o(tb_adv),
      .period_match_o(tb_match));

   task automatic wrap_up();
      $display("Counts: %0d checked, %0d failed", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Classic single cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      wb_cyc  <= 1'b1;
      wb_stb  <= 1'b1;
      wb_we   <= w;
      wb_adr  <= a;
      wb_sel  <= 4'h3;
      wb_wdat <= d;
      do @(posedge clk_i); while (wb_ack !== 1'b1 && ++k < 20);
      if (wb_ack !== 1'b1)
      begin
         fails++;
         wrap_up();
      end
      rd = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   // High cycles over one full period after a period match
   task automatic measure(input int exp);
      int k;
      int hi;
      k = 0;
      hi = 0;
      do @(posedge clk_i); while (tb_match !== 1'b1 && ++k < 40);
      repeat (int'(per_val) + 1) @(posedge clk_i) hi += int'(pin);
      chk(32'(hi), 32'(exp));
      chk(32'(tb_match), 32'h1);
   endtask

   initial
   begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (dual_tab[i]) rd_chk(4'(i * 4 % 18), 32'h0);
      wb(1'b1, 4'h2, 32'hffff);
      rd_chk(4'h2, 32'h0);
      chk(32'(pin_oe), 32'h0);
      $display("test map done");
      foreach (dual_tab[i])
      begin
         tmr_run <= 1'b0;
         per_val <= 16'(dual_tab[i][0]);
         wb(1'b1, ADDR_CMPA, 32'(dual_tab[i][1]));
         wb(1'b1, ADDR_CMPB, 32'(dual_tab[i][2]));
         wb(1'b1, ADDR_CTRL, {29'h0, MODE_DUAL});
         chk(32'(pin), 32'h0);
         wb(1'b1, ADDR_STAT, 32'h3);
         tmr_run <= 1'b1;
         n = 0;
         do @(posedge clk_i); while (pin !== 1'b1 && ++n < 20);
         chk((pin === 1'b1) ? 32'(n + 1) : 32'h0, 32'(dual_tab[i][3]));
         repeat (40) @(posedge clk_i);
         wb(1'b0, ADDR_STAT, 32'h0);
         chk(32'(rd[STAT_CH_BIT]), 32'(dual_tab[i][4]));
      end
      $display("test dual done");
      tmr_run <= 1'b0;
      per_val <= 16'd15;
      wb(1'b1, ADDR_CTRL, 32'h0);
      wb(1'b1, ADDR_CMPB, 32'h3);
      wb(1'b1, ADDR_CMPA, 32'h5);
      wb(1'b1, ADDR_CTRL, {29'h0, MODE_PWM});
      wb(1'b1, ADDR_STAT, 32'h3);
      tmr_run <= 1'b1;
      measure(3);
      wb(1'b1, ADDR_CMPB, 32'h6);
      wb(1'b1, ADDR_CMPA, 32'h9);
      rd_chk(ADDR_CMPA, 32'h3);
      measure(6);
      rd_chk(ADDR_CMPA, 32'h6);
      rd_chk(ADDR_STAT, 32'h2);
      $display("test pwm done");
      wb(1'b1, ADDR_CTRL, {29'h0, MODE_PWM_FLT});
      flt_b <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk(32'(pin_oe), 32'h1);
      flt_b <= 1'b1;
      flt_a <= 1'b0;
      #1;
      chk(32'(pin_oe), 32'h0);
      repeat (2) @(posedge clk_i);
      rd_chk(ADDR_CTRL, 32'h17);
      wb(1'b0, ADDR_STAT, 32'h0);
      chk(32'(rd[STAT_CH_BIT]), 32'h1);
      flt_a <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk(32'(pin_oe), 32'h0);
      rd_chk(ADDR_CTRL, 32'h17);
      wb(1'b1, ADDR_CTRL, {29'h0, MODE_PWM_FLT});
      repeat (2) @(posedge clk_i);
      chk(32'(pin_oe), 32'h1);
      rd_chk(ADDR_CTRL, 32'h7);
      wb(1'b1, ADDR_CTRL, {29'h0, MODE_PWM});
      flt_a <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk(32'(pin_oe), 32'h1);
      flt_a <= 1'b1;
      $display("test fault done");
      wrap_up();
   end
endmodule

bind ocpwm_channel ocpwm_channel_sva #(.CHANNEL(CHANNEL), .WIDTH(WIDTH)) ocpwm_channel_sva_i (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .timebase_count_i(timebase_count_i),
   .timebase_advance_i(timebase_advance_i), .period_match_i(period_match_i),
   .fault_input_a_i(fault_input_a_i), .fault_input_b_i(fault_input_b_i),
   .compare_output_pin_o(compare_output_pin_o), .compare_output_pin_oe_o(compare_output_pin_oe_o),
   .channel_event_flag_o(channel_event_flag_o), .period_event_flag_o(period_event_flag_o));
`default_nettype wire

// ===== tb/ocpwm_tmr_model.sv
`default_nettype none
module ocpwm_tmr_model
#(
   parameter int WIDTH = 16
)
(
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Bench control
   input  wire logic             run_i,
   input  wire logic [WIDTH-1:0] period_value_i,
   // Timebase
   output logic      [WIDTH-1:0] timebase_count_o,
   output logic                  advance_o,
   output logic                  period_match_o
);
   timeunit 1ns;
   timeprecision 1ps;

   wire logic             wrap       = (timebase_count_o == period_value_i);
   wire logic [WIDTH-1:0] next_count = wrap ? '0 : timebase_count_o + 1'b1;

   // Cleared while stopped, so each run starts a fresh pass
   always_ff @(posedge clk_i)
   begin
      timebase_count_o <= (rst_i || !run_i) ? '0 : next_count;
      advance_o        <= !rst_i && run_i;
      period_match_o   <= !rst_i && run_i && wrap;
   end
endmodule
`default_nettype wire
